/* File: rtl/swp_pkg.sv */
// constants, carrier types and decode functions for the status write-protection block
package swp_pkg;

  // bus geometry
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADR_W-1:0] OFF_LATCH = 8'h04;
  localparam logic [ADR_W-1:0] OFF_SRWRITE = 8'h08;
  localparam logic [ADR_W-1:0] OFF_SWRESET = 8'h0c;
  localparam logic [ADR_W-1:0] OFF_PINCFG = 8'h10;
  localparam logic [ADR_W-1:0] OFF_NVCOPY = 8'h14;

  // status register field positions
  localparam int ST_LO_BIT = 0;
  localparam int ST_HI_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_WEL_BIT = 3;
  localparam int ST_QE_BIT = 4;
  localparam int ST_PAUSE_BIT = 5;

  // status-write command field positions
  localparam int SRW_LO_BIT = 0;
  localparam int SRW_HI_BIT = 1;
  localparam int SRW_LOCK_BIT = 2;
  localparam int SRW_QE_BIT = 3;
  localparam int SRW_CFG_LSB = 8;

  // pin configuration field position
  localparam int CFG_ROLE_BIT = 7;

  // reset values
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic QE_RESET = 1'b0;
  localparam logic [7:0] PINCFG_RESET = 8'h00;
  localparam logic PIN_IDLE = 1'b1;

  // protect pair, high bit first
  typedef struct packed {
    logic hi;
    logic lo;
  } prot_type;

  // one classic wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wb_req_type;

  // whole state of the protection block
  typedef struct packed {
    prot_type vprot;
    prot_type nvprot;
    logic nvlock;
    logic write_latch_flag;
    logic qe;
    logic [7:0] pincfg;
    logic pause;
    logic dev_rst;
    logic hold_prev;
    logic ack;
    logic [DATA_W-1:0] dat;
  } state_type;

  localparam state_type ST_RESET = '{
    vprot: PROT_RESET,
    nvprot: PROT_RESET,
    nvlock: 1'b0,
    write_latch_flag: 1'b0,
    qe: QE_RESET,
    pincfg: PINCFG_RESET,
    pause: 1'b0,
    dev_rst: 1'b0,
    hold_prev: PIN_IDLE,
    ack: 1'b0,
    dat: 32'h0000_0000
  };

  // decide whether a status write may land
  function automatic logic write_allowed(prot_type p, logic lock, logic wp_high, logic write_latch_flag);
    logic ok;
    ok = 1'b0;
    case ({p.hi, p.lo})
      2'b00: ok = write_latch_flag;
      2'b01: ok = write_latch_flag & wp_high;
      2'b10: ok = 1'b0;
      2'b11: ok = 1'b0 & ~lock;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : write_allowed

  // protect pair to load on any device reset
  function automatic prot_type reload_prot(prot_type nv, logic lock);
    prot_type v;
    v = '{hi: 1'b0, lo: 1'b0};
    case ({nv.hi, nv.lo})
      2'b00: v = '{hi: 1'b0, lo: 1'b0};
      2'b01: v = '{hi: 1'b0, lo: 1'b1};
      2'b10: v = '{hi: 1'b0, lo: 1'b0};
      2'b11: v = lock ? prot_type'(2'h3) : prot_type'(2'h1);
      default: v = '{hi: 1'b0, lo: 1'b0};
    endcase
    return v;
  endfunction : reload_prot

endpackage : swp_pkg

/* File: rtl/swp_sync.sv */
// two-flop synchroniser for pins arriving from outside the clock domain
module swp_sync
  import swp_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '1
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // asynchronous pins in, settled copy out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // first stage is read only by the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_type;

  sync_type st;
  sync_type next_st;

  // shift one stage per enabled clock
  always_comb begin
    next_st.meta = d_i;
    next_st.q = st.meta;
  end

  // idle level during reset keeps edge detectors quiet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{meta: INIT, q: INIT};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign q_o = st.q;

endmodule : swp_sync

/* File: rtl/swp_protect.sv */
// status-register write protection with reload, pin role select and wishbone slave
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
module swp_protect
  import swp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins, all asynchronous
  input wire logic sclk_i,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // block outputs
  output logic pause_o,
  output logic dev_reset_o,
  output logic quad_io_o,
  output logic hold_is_reset_o
);

  state_type st; // registered state
  state_type next_st; // next state
  wb_req_type req; // bundled bus request
  logic [2:0] pins_s; // synchronised sclk, wp, hold
  logic sclk_s; // settled serial clock
  logic wp_s; // settled protect pin
  logic hold_s; // settled pause/reset pin
  logic take; // request accepted this edge
  logic wr_cmd; // status-write command taken
  logic sw_rst; // software reset command taken
  logic hw_rst; // pin reset edge seen
  logic dev_evt; // any device reset this edge
  logic wp_high; // protect pin counts as high
  logic allowed; // status write would land

  // pins pass two flops before anything reads them
  swp_sync #(
    .W(3),
    .INIT({PIN_IDLE, PIN_IDLE, PIN_IDLE})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({sclk_i, wp_n_i, hold_n_i}),
    .q_o(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign wp_s = pins_s[1];
  assign hold_s = pins_s[0];

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // one request per ack; the cycle in which ack stands blocks a repeat
  assign take = req.cyc & req.stb & ~st.ack;
  assign wr_cmd = take & req.we & req.sel[0] & (req.adr == OFF_SRWRITE);
  assign sw_rst = take & req.we & req.sel[0] & (req.adr == OFF_SWRESET);

  // quad mode turns the protect pin into data, so it no longer guards
  assign wp_high = st.qe | wp_s;

  // pin reset only when configured for it and quad is off
  assign hw_rst = ~st.qe & st.pincfg[CFG_ROLE_BIT] & st.hold_prev & ~hold_s;
  assign dev_evt = hw_rst | sw_rst;

  assign allowed = write_allowed(st.vprot, st.nvlock, wp_high, st.write_latch_flag);

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.dev_rst = 1'b0;
    next_st.hold_prev = hold_s;
    // bus answer: one cycle after the request, unmapped reads give zero
    if (take) begin
      next_st.ack = 1'b1;
      next_st.dat = '0;
      if (!req.we) begin
        case (req.adr)
          OFF_STATUS: begin
            next_st.dat[ST_LO_BIT] = st.vprot.lo;
            next_st.dat[ST_HI_BIT] = st.vprot.hi;
            next_st.dat[ST_LOCK_BIT] = st.nvlock;
            next_st.dat[ST_WEL_BIT] = st.write_latch_flag;
            next_st.dat[ST_QE_BIT] = st.qe;
            next_st.dat[ST_PAUSE_BIT] = st.pause;
          end
          OFF_PINCFG: next_st.dat[7:0] = st.pincfg;
          OFF_NVCOPY: begin
            next_st.dat[ST_LO_BIT] = st.nvprot.lo;
            next_st.dat[ST_HI_BIT] = st.nvprot.hi;
            next_st.dat[ST_LOCK_BIT] = st.nvlock;
          end
          default: next_st.dat = '0;
        endcase
      end
    end
    // write latch set by its own command
    if (take && req.we && req.sel[0] && req.adr == OFF_LATCH) begin
      next_st.write_latch_flag = 1'b1;
    end
    // status write lands only when protection allows; otherwise nothing moves
    if (wr_cmd && allowed) begin
      next_st.vprot = '{hi: req.dat[SRW_HI_BIT], lo: req.dat[SRW_LO_BIT]};
      next_st.nvprot = '{hi: req.dat[SRW_HI_BIT], lo: req.dat[SRW_LO_BIT]};
      // a status write can only set the lock, never clear it
      next_st.nvlock = st.nvlock | req.dat[SRW_LOCK_BIT];
      next_st.qe = req.dat[SRW_QE_BIT];
      if (req.sel[1]) begin
        next_st.pincfg = req.dat[SRW_CFG_LSB +: 8];
      end
      next_st.write_latch_flag = 1'b0;
    end
    // pause follows the pin only while sclk is low, so a byte is not split mid-bit
    if (st.qe || st.pincfg[CFG_ROLE_BIT]) begin
      next_st.pause = 1'b0;
    end else if (!sclk_s) begin
      next_st.pause = ~hold_s;
    end
    // device reset reloads the volatile pair and clears the latch, overriding a write to them in the same cycle
    if (dev_evt) begin
      next_st.vprot = reload_prot(st.nvprot, st.nvlock);
      next_st.write_latch_flag = 1'b0;
      next_st.pause = 1'b0;
      next_st.dev_rst = 1'b1;
    end
  end

  // state register; a low enable freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_RESET;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // every output straight from a state flop
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign pause_o = st.pause;
  assign dev_reset_o = st.dev_rst;
  assign quad_io_o = st.qe;
  assign hold_is_reset_o = st.pincfg[CFG_ROLE_BIT];

  // open protection: an enabled write copies the new pair
  AST_SOFT_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && st.vprot == 2'b00 && st.write_latch_flag && !dev_evt
    |=> st.vprot == $past(wb_dat_i[1:0]) && !st.write_latch_flag)
    else $error("open protection did not take the write");

  // pin protection with pin low: nothing changes
  AST_HW_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && st.vprot == 2'b01 && !wp_s && !st.qe && !dev_evt
    |=> $stable(st.nvprot) && $stable(st.qe) && $stable(st.pincfg) && $stable(st.write_latch_flag))
    else $error("write landed while protect pin low");

  // pin protection with pin high and latch set: write lands
  AST_HW_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && st.vprot == 2'b01 && wp_s && st.write_latch_flag && !dev_evt
    |=> st.nvprot == $past(wb_dat_i[1:0]))
    else $error("write refused with protect pin high");

  // lockdown pair holds until a device reset
  AST_LOCKDOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    st.vprot == 2'b10 && !(ce_i && dev_evt) |=> st.vprot == 2'b10 && $stable(st.qe))
    else $error("lockdown lifted without reset");

  // unlocked full protection keeps the stored copy
  AST_LOCK11: assert property (@(posedge clk_i) disable iff (rst_i)
    st.vprot == 2'b11 && !st.nvlock && !(ce_i && dev_evt)
    |=> $stable(st.nvprot) && $stable(st.pincfg))
    else $error("write landed under full protection");

  // locked full protection survives even device resets
  AST_OTP: assert property (@(posedge clk_i) disable iff (rst_i)
    st.vprot == 2'b11 && st.nvlock |=> st.vprot == 2'b11 && st.nvlock && $stable(st.pincfg))
    else $error("permanent protection was lifted");

  // reload table on every device reset, with a marker pulse
  AST_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && dev_evt |=> st.vprot == reload_prot($past(st.nvprot), $past(st.nvlock))
    && dev_reset_o && !st.write_latch_flag)
    else $error("volatile pair not reloaded correctly");

  // pause only when configured for pause and quad is off
  AST_PAUSE_ROLE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pause_o) |-> $past(!st.qe && !st.pincfg[CFG_ROLE_BIT] && !hold_s && !sclk_s))
    else $error("pause raised in the wrong role");

  // quad mode ignores the protect pin
  AST_QE_WP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && st.qe && st.vprot == 2'b01 && st.write_latch_flag && !dev_evt
    |=> st.vprot == $past(wb_dat_i[1:0]))
    else $error("protect pin still guarding in quad mode");

  // refused write leaves the volatile pair, lock, write latch and pin config as they were
  AST_REFUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && !allowed && !dev_evt
    |=> $stable(st.vprot) && $stable(st.nvlock) && $stable(st.write_latch_flag) && $stable(st.pincfg))
    else $error("refused write changed state");

  // ack is a single cycle; a low enable may legally freeze it
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // a taken request is answered at the very next edge
  AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && take |=> wb_ack_o)
    else $error("taken request not acknowledged");

  // read data stands until the next taken request, so a slow master still sees it
  AST_DAT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ce_i && take) |=> $stable(wb_dat_o))
    else $error("read data changed without a request");

  // the latch command sets the write latch unless a device reset clears it
  AST_LATCH_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_LATCH && !dev_evt |=> st.write_latch_flag)
    else $error("write latch not set by its command");

  // a falling pin in reset role gives a device reset pulse
  AST_PIN_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !st.qe && st.pincfg[CFG_ROLE_BIT] && st.hold_prev && !hold_s |=> dev_reset_o)
    else $error("pin reset not taken in reset role");

  // quad mode silences both pin roles
  AST_QUAD_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st.qe && !sw_rst |=> !pause_o && !dev_reset_o)
    else $error("pause or pin reset active in quad mode");

  // with the pin in pause role it never resets the device
  AST_PAUSE_NO_RST: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !st.pincfg[CFG_ROLE_BIT] && !sw_rst |=> !dev_reset_o)
    else $error("pin reset while in pause role");

  COV_OPEN_WRITE: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && allowed);
  COV_PIN_REFUSE: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && st.vprot == 2'b01 && !wp_high);
  COV_HW_RESET: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && hw_rst);
  COV_PAUSE: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(pause_o));
  COV_QUAD_BYPASS: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_cmd && allowed && st.qe && st.vprot == 2'b01 && !wp_s);

endmodule : swp_protect

/* File: testbench/swp_host_model.sv */
// behavioural far-side host driving the serial clock and the protect and pause pins
module swp_host_model (
  // commands from the bench
  input wire logic frame_i,
  input wire logic wp_level_i,
  input wire logic hold_level_i,
  // pins toward the device
  output logic sclk_o,
  output logic wp_n_o,
  output logic hold_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // serial clock stands low between frames, 80 ns period inside one
  // the 3 ns offset keeps its edges clear of the system clock edges
  initial begin
    sclk_o = 1'b0;
    #3;
    forever begin
      #40;
      sclk_o = frame_i ? ~sclk_o : 1'b0;
    end
  end

  // both pins are plain levels the bench commands; no pull needed
  assign wp_n_o = wp_level_i;
  assign hold_n_o = hold_level_i;
endmodule : swp_host_model

/* File: testbench/tb_swp_protect.sv */
// self-checking bench for the status write-protection block
module tb_swp_protect
  import swp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // one table row: lock and pair written {lock,hi,lo}, pin level, attempt accepted, reloaded pair {hi,lo}
  typedef struct packed {
    logic [2:0] val;
    logic wp;
    logic acc;
    logic [1:0] rel;
  } row_type;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  wb_req_type req = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o, sclk, wp_n, hold_n, pause_o, dev_reset_o, quad_io_o, hold_is_reset_o;
  logic frame = 1'b0;
  logic wp_lvl = 1'b1;
  logic hold_lvl = 1'b1;
  logic [DATA_W-1:0] d;
  int failures = 0;
  int comparisons = 0;
  int rst_cnt = 0;
  int base;
  row_type rows [6] = '{
    '{3'h0, 1'b0, 1'b1, 2'h0}, '{3'h1, 1'b0, 1'b0, 2'h1}, '{3'h1, 1'b1, 1'b1, 2'h0},
    '{3'h2, 1'b1, 1'b0, 2'h0}, '{3'h3, 1'b1, 1'b0, 2'h1}, '{3'h7, 1'b1, 1'b0, 2'h3}};

  always #5 clk_i = ~clk_i;

  swp_host_model host (.frame_i(frame), .wp_level_i(wp_lvl), .hold_level_i(hold_lvl),
    .sclk_o(sclk), .wp_n_o(wp_n), .hold_n_o(hold_n));

  swp_protect dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sclk_i(sclk), .wp_n_i(wp_n), .hold_n_i(hold_n), .pause_o(pause_o),
    .dev_reset_o(dev_reset_o), .quad_io_o(quad_io_o), .hold_is_reset_o(hold_is_reset_o));

  // count device reset pulses, whatever their source
  always @(posedge clk_i) if (dev_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string msg);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // classic single cycle; entered just after a rising edge, released after the ack edge
  task automatic wb(input logic we, input logic [3:0] sel, input logic [ADR_W-1:0] adr,
                    input logic [DATA_W-1:0] dat, output logic [DATA_W-1:0] rdat);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    // ack is looked at mid-cycle where it is settled; only the watchdog ends this wait
    do begin
      @(negedge clk_i);
    end while (wb_ack_o !== 1'b1);
    // the rising edge that samples ack high; read data stands until the next request
    @(posedge clk_i);
    rdat = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [DATA_W-1:0] dat);
    logic [DATA_W-1:0] x;
    wb(1'b1, (dat[15:8] != 8'h00) ? 4'h3 : 4'h1, adr, dat, x);
  endtask : wr

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  initial begin
    @(posedge clk_i);
    frame <= 1'b1;
    // protection table: set pair, try to clear it, then a software reset
    foreach (rows[i]) begin
      do_reset();
      wp_lvl <= rows[i].wp;
      wr(OFF_LATCH, 32'h0000_0001);
      wr(OFF_SRWRITE, {29'h0, rows[i].val});
      wb(1'b0, 4'hf, OFF_STATUS, 32'h0, d);
      check(d[3:0], {1'b0, rows[i].val}, "pair set");
      wr(OFF_LATCH, 32'h0000_0001);
      wr(OFF_SRWRITE, 32'h0000_0000);
      wb(1'b0, 4'hf, OFF_STATUS, 32'h0, d);
      check(d[3:0], rows[i].acc ? 4'h0 : {1'b1, rows[i].val}, "write attempt");
      wr(OFF_SWRESET, 32'h0000_0001);
      wb(1'b0, 4'hf, OFF_STATUS, 32'h0, d);
      check(d[3:0], {1'b0, rows[i].val[2], rows[i].rel}, "reload");
    end
    frame <= 1'b0;
    // pause role by default
    do_reset();
    // a low enable freezes the synchronisers and the pause flag
    ce <= 1'b0;
    hold_lvl <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(pause_o, 1'b0, "frozen pause");
    ce <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(pause_o, 1'b1, "pause");
    hold_lvl <= 1'b1;
    repeat (8) @(posedge clk_i);
    // switch pin to reset role
    wr(OFF_LATCH, 32'h0000_0001);
    wr(OFF_SRWRITE, 32'h0000_8000);
    wb(1'b0, 4'hf, OFF_PINCFG, 32'h0, d);
    check(d, 32'h0000_0080, "pin config");
    check(hold_is_reset_o, 1'b1, "reset role");
    base = rst_cnt;
    hold_lvl <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(rst_cnt - base, 1, "pin reset");
    check(pause_o, 1'b0, "no pause in reset role");
    hold_lvl <= 1'b1;
    repeat (8) @(posedge clk_i);
    // quad on: pin is data only
    wr(OFF_LATCH, 32'h0000_0001);
    wr(OFF_SRWRITE, 32'h0000_8008);
    check(quad_io_o, 1'b1, "quad");
    base = rst_cnt;
    hold_lvl <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(rst_cnt - base, 0, "quad pin reset");
    check(pause_o, 1'b0, "quad pause");
    hold_lvl <= 1'b1;
    // quad mode: a low protect pin no longer guards the pin-protected pair
    wp_lvl <= 1'b0;
    wr(OFF_LATCH, 32'h0000_0001);
    wr(OFF_SRWRITE, 32'h0000_8009);
    wr(OFF_LATCH, 32'h0000_0001);
    wr(OFF_SRWRITE, 32'h0000_8008);
    wb(1'b0, 4'hf, OFF_STATUS, 32'h0, d);
    check(d[7:0], 8'h10, "quad ignores protect pin");
    wb(1'b0, 4'hf, 8'h20, 32'h0, d);
    check(d, 32'h0, "unmapped read");
    final_report();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #300us;
    failures++;
    final_report();
  end
endmodule : tb_swp_protect
